// >>> include/tr_pkg.sv
// Package for the trigger router: register map, field layout, timing.
package tr_pkg;

    // Time base and system clock
    localparam int unsigned TIME_STEP_NS  = 10;   // Counter LSB in ns
    localparam int unsigned CLK_PERIOD_NS = 100;  // sys_clk period, 10 MHz
    localparam logic [63:0] TIME_INC      =
        64'(CLK_PERIOD_NS / TIME_STEP_NS);        // Counter steps per cycle
    localparam int unsigned TIME_W        = 64;

    // Line counts
    localparam int unsigned NUM_FP    = 3;
    localparam int unsigned NUM_STAR  = 13;
    localparam int unsigned NUM_TRIG  = 8;
    localparam int unsigned NUM_DEST  = NUM_FP + NUM_STAR + NUM_TRIG;
    localparam int unsigned NUM_REF   = 4;

    // Route source codes
    localparam logic [4:0] SRC_GROUND  = 5'h00;
    localparam logic [4:0] SRC_FP0     = 5'h01;
    localparam logic [4:0] SRC_STAR0   = 5'h04;
    localparam logic [4:0] SRC_TRIG0   = 5'h11;
    localparam logic [4:0] SRC_CLK10   = 5'h19;
    localparam logic [4:0] SRC_EVENT   = 5'h1A;
    localparam logic [4:0] SRC_GENCLK  = 5'h1B;

    // Time reference selections
    localparam logic [2:0] REF_FREE    = 3'h0;
    localparam logic [2:0] REF_SAT     = 3'h1;
    localparam logic [2:0] REF_IRIG    = 3'h2;
    localparam logic [2:0] REF_PPS     = 3'h3;
    localparam logic [2:0] REF_PTP     = 3'h4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_TIME_LO  = 8'h08;
    localparam logic [7:0] OFS_TIME_HI  = 8'h0C;
    localparam logic [7:0] OFS_EVT_LO   = 8'h10;
    localparam logic [7:0] OFS_EVT_HI   = 8'h14;
    localparam logic [7:0] OFS_EVT_CTRL = 8'h18;
    localparam logic [7:0] OFS_GC_HIGH  = 8'h20;
    localparam logic [7:0] OFS_GC_LOW   = 8'h24;
    localparam logic [7:0] OFS_GC_STA_L = 8'h28;
    localparam logic [7:0] OFS_GC_STA_H = 8'h2C;
    localparam logic [7:0] OFS_GC_STO_L = 8'h30;
    localparam logic [7:0] OFS_GC_STO_H = 8'h34;
    localparam logic [7:0] OFS_GC_CTRL  = 8'h38;
    localparam logic [7:0] OFS_ROUTE0   = 8'h40;

    // CTRL fields
    localparam int unsigned CTRL_REF_LSB   = 0;
    localparam int unsigned CTRL_CLOCK_OUTPUT_CONNECTOR    = 3;
    localparam int unsigned CTRL_REPL_EN   = 4;
    localparam int unsigned CTRL_REPL_SRC  = 5;
    // STATUS fields
    localparam int unsigned STAT_SLOT2     = 0;
    localparam int unsigned STAT_REPL      = 1;
    localparam int unsigned STAT_ARMED     = 2;
    localparam int unsigned STAT_GC_RUN    = 3;
    // Route word fields
    localparam int unsigned RT_SRC_LSB     = 0;
    localparam int unsigned RT_INV         = 5;
    localparam int unsigned RT_SYNC        = 6;
    localparam int unsigned RT_EN          = 7;

    // Per-destination route configuration
    typedef struct packed {
        logic       en;
        logic       sync;
        logic       inv;
        logic [4:0] src;
    } tr_route_s;

    localparam tr_route_s ROUTE_RST = '0;
    localparam logic [7:0] CTRL_RST = 8'h00;

endpackage

// >>> sim/testbench.sv
// Self-checking bench for the trigger router.
`timescale 1ns/1ps
module testbench import tr_pkg::*;;
    logic                sys_clk, reset_n, avs_read, avs_write;
    logic [7:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata, v, w;
    logic                avs_waitrequest, osc, cin, c10, cko, ro, roe;
    logic [NUM_FP-1:0]   fo;
    logic [NUM_STAR-1:0] so, se;
    logic [NUM_TRIG-1:0] tw, td, to, te;
    int                  bad_count, total_checks, n;

    tr_router tr_router_inst (.sys_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .ref_pulse(4'h0), .slot_two_n(1'b0),
        .compensated_oscillator(osc), .clock_input_connector(cin),
        .backplane_clk10(c10), .clock_output_connector(cko),
        .clk10_repl_out(ro), .clk10_repl_oe(roe),
        .front_panel_io_line_in(~fo), .front_panel_io_line_out(fo),
        .front_panel_io_line_oe(), .star_in(~so), .star_out(so),
        .star_oe(se), .trig_in(tw), .trig_out(to), .trig_oe(te));
    tr_far_end tr_far_end_inst (.trig_drive(td), .trig_out(to),
        .trig_oe(te), .trig_wire(tw), .osc(osc), .clk_in(cin), .clk10(c10));

    always #50 sys_clk = ~sys_clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // One bus access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic r, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        {avs_read, avs_write, avs_address, avs_writedata} <= {r, !r, a, d};
        n = 0;
        do begin @(posedge sys_clk); n++; end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin bad_count++; wrap_up(); end
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, v);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0, v);
        check(v, exp);
    endtask

    initial begin repeat (20000) @(posedge sys_clk); bad_count++; wrap_up(); end
    initial begin
        {sys_clk, reset_n, avs_read, avs_write, avs_address} = '0;
        {avs_writedata, td, bad_count, total_checks} = '0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_STATUS, 32'h1);
        rdc(8'hFC, 32'h0);
        // Clock out and replacement line, both sources
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL, 32'(s) << CTRL_CLOCK_OUTPUT_CONNECTOR);
            check(32'(s ? c10 : osc), 32'(cko));
            wr(OFS_CTRL, 32'h10 | 32'(s) << CTRL_REPL_SRC);
            check(32'({roe, ro}), 32'({1'b1, s ? cin : osc}));
            wr(OFS_CTRL, 32'h0);
            check(32'({roe, ro}), 32'h0);
        end
        // Free-run preset, then two reads three cycles apart
        wr(OFS_TIME_LO, 32'h0);
        wr(OFS_TIME_HI, 32'h0);
        bus(1'b1, OFS_TIME_LO, 32'h0, w);
        bus(1'b1, OFS_TIME_LO, 32'h0, v);
        check(v - w, 32'h1E);
        // Future event onto bused line 0
        wr(OFS_EVT_LO, 32'h3E8);
        wr(OFS_EVT_HI, 32'h0);
        wr(OFS_ROUTE0 + 8'h40, 32'h9A);
        wr(OFS_EVT_CTRL, 32'h1);
        rdc(OFS_STATUS, 32'h5);
        for (n = 0; n < 200 && to[0] !== 1'b1; n++) @(negedge sys_clk);
        check(32'(n < 200), 32'h1);
        @(negedge sys_clk) check(32'(to[0]), 32'h0);
        @(posedge sys_clk) bus(1'b1, OFS_TIME_LO, 32'h0, v);
        check(32'(v >= 32'h3E8), 32'h1);
        // Trig 1 inverted onto star 0; star 1 unrouted
        wr(OFS_ROUTE0 + 8'h0C, 32'hB2);
        for (int s = 0; s < 2; s++) begin
            td <= s ? 8'h02 : 8'h00;
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk) check(32'({se[1:0], so[1:0]}),
                32'({3'b010, s == 0}));
            @(posedge sys_clk);
        end
        wrap_up();
    end
endmodule

bind tr_router tr_router_properties tr_router_properties_inst (.sys_clk,
    .reset_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .slot_two_n, .compensated_oscillator, .clock_input_connector,
    .backplane_clk10, .clock_output_connector, .clk10_repl_out,
    .clk10_repl_oe, .star_out, .star_oe, .trig_out, .trig_oe);

// >>> sim/tr_far_end.sv
// Far-side model: clock sources and the shared trigger bus.
`timescale 1ns/1ps
module tr_far_end
    import tr_pkg::*;
(
    input  logic [NUM_TRIG-1:0] trig_drive, // Far-side value
    input  logic [NUM_TRIG-1:0] trig_out,   // Router drive value
    input  logic [NUM_TRIG-1:0] trig_oe,    // Router enables
    output logic [NUM_TRIG-1:0] trig_wire,  // Resolved lines
    output logic                osc,        // Oscillator
    output logic                clk_in,     // Clock input
    output logic                clk10       // Backplane clock
);
    // Osc and clock input at 10 MHz, clk10 at a 620 ns period, on phases that never meet a sys_clk edge
    initial begin
        osc = 1'b0;
        clk_in = 1'b0;
        clk10 = 1'b0;
        fork
            begin #23; forever #50 osc = ~osc; end
            begin #37; forever #50 clk_in = ~clk_in; end
            begin #7; forever #310 clk10 = ~clk10; end
        join
    end
    // Other modules drive where the router does not
    assign trig_wire = (trig_oe & trig_out) | (~trig_oe & trig_drive);
endmodule

// >>> sim/tr_router_properties.sv
// Concurrent checks on the trigger router ports.
`timescale 1ns/1ps
module tr_router_properties
    import tr_pkg::*;
(
    input logic                sys_clk,                // Clock
    input logic                reset_n,                // Sync reset
    input logic                avs_read,               // Read
    input logic                avs_write,              // Write
    input logic [31:0]         avs_readdata,           // Read data
    input logic                avs_waitrequest,        // Stall
    input logic                slot_two_n,             // Slot strap
    input logic                compensated_oscillator, // Osc
    input logic                clock_input_connector,  // Ext clock
    input logic                backplane_clk10,        // Clk10
    input logic                clock_output_connector, // Clock out
    input logic                clk10_repl_out,         // Repl line
    input logic                clk10_repl_oe,          // Repl drive
    input logic [NUM_STAR-1:0] star_out,               // Star out
    input logic [NUM_STAR-1:0] star_oe,                // Star drive
    input logic [NUM_TRIG-1:0] trig_out,               // Trig out
    input logic [NUM_TRIG-1:0] trig_oe                 // Trig drive
);
    // One clock domain
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    chk_wait_cause: assert property (
        avs_waitrequest |-> avs_read || avs_write)
        else $error("stall without a request");
    chk_rd_stands: assert property (
        !$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved");
    chk_clock_output_connector_src: assert property (
        clock_output_connector == backplane_clk10
        || clock_output_connector == compensated_oscillator)
        else $error("clock out from a wrong source");
    chk_repl_src: assert property (
        clk10_repl_oe |-> clk10_repl_out == compensated_oscillator
        || clk10_repl_out == clock_input_connector)
        else $error("replacement line from a wrong source");
    chk_repl_quiet: assert property (!clk10_repl_oe |-> !clk10_repl_out)
        else $error("replacement line active while off");
    chk_repl_slot: assert property (clk10_repl_oe |-> !slot_two_n)
        else $error("replacement outside slot two");
    chk_line_gate: assert property (
        (star_out & ~star_oe) == '0 && (trig_out & ~trig_oe) == '0)
        else $error("undriven line high");
endmodule

// >>> src/tr_clkgen.sv
// Time-scheduled clock generator with programmable high and low lengths.
`timescale 1ns/1ps
module tr_clkgen
    import tr_pkg::*;
#(
    parameter int unsigned LW = 32
) (
    input  wire logic              sys_clk,    // System clock
    input  wire logic              reset_n,    // Synchronous reset
    input  wire logic              enable,     // Generator armed
    input  wire logic [TIME_W-1:0] now,        // Current time count
    input  wire logic [TIME_W-1:0] start_time, // First high edge
    input  wire logic [TIME_W-1:0] stop_time,  // Output forced low here
    input  wire logic [LW-1:0]     high_len,   // High time in steps
    input  wire logic [LW-1:0]     low_len,    // Low time in steps
    output logic                   clk_out,    // Generated clock level
    output logic                   running     // Inside start..stop
);
    localparam logic [LW:0] STEP = (LW+1)'(TIME_INC);

    logic [LW:0] remain_q;
    logic [LW:0] hi_len;
    logic [LW:0] lo_len;

    // Zero length would stall the toggle; treat it as one step
    assign hi_len = (high_len == '0) ? (LW+1)'(1) : {1'b0, high_len};
    assign lo_len = (low_len == '0) ? (LW+1)'(1) : {1'b0, low_len};

    // Phase tracked in steps, so lengths not divisible by the clock
    // period still average to the programmed frequency
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !enable) begin
            running  <= 1'b0;
            clk_out  <= 1'b0;
            remain_q <= '0;
        end else if (!running) begin
            if (now >= start_time && now < stop_time) begin // (RQ5)
                running  <= 1'b1;
                clk_out  <= 1'b1;
                remain_q <= hi_len;
            end
        end else if (now >= stop_time) begin // (RQ5)
            running <= 1'b0;
            clk_out <= 1'b0;
        end else if (remain_q <= STEP) begin // (RQ4)
            clk_out  <= ~clk_out;
            remain_q <= remain_q - STEP + (clk_out ? lo_len : hi_len);
        end else begin
            remain_q <= remain_q - STEP;
        end
    end

endmodule

// >>> src/tr_router.sv
// Trigger router with time base, event and clock generation.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
//
// Contract
// (RQ1) Time counter LSB is 10 ns; all events and clocks use it.
// (RQ2) Counter follows satellite, IRIG-B, PPS, 1588 reference, or runs free.
// (RQ3) Emit trigger event when counter reaches the scheduled time.
// (RQ4) Generated clock high and low lengths set independently in 10ns steps.
// (RQ5) Generated clock runs from programmed start time to programmed end time.
// (RQ6) In slot 2, oscillator may drive the backplane 10 MHz replacement line.
// (RQ7) Replacement only after software enables it; native clock by default.
// (RQ8) Compensated oscillator runs free, never steered by the time counter.
// (RQ9) Each destination can invert polarity of its routed signal.
// (RQ10) Clock input connector may drive the backplane replacement line.
// (RQ11) Clock output connector takes oscillator or backplane 10 MHz clock.
// (RQ12) Route has source and destination; synchronous route retimes to a clock.
// (RQ13) Panel, star, trigger lines and clk10 route to panel, star, trigger.
// (RQ14) Events and generated clocks never reach the clock connectors.
// (RQ15) Clock input or oscillator reach trigger lines only via clk10, at 10 MHz.
// (RQ16) Trigger outputs may retime to clk10, except future time events.
// (RQ17) Route settings stored per destination; unrouted destination drives low; here it outputs low with its drive enable off.
module tr_router
    import tr_pkg::*;
(
    input  wire logic                sys_clk,          // 10 MHz system clock
    input  wire logic                reset_n,          // Sync reset, active low
    // Avalon-MM slave
    input  wire logic [7:0]          avs_address,      // Byte address
    input  wire logic                avs_read,         // Read request
    input  wire logic                avs_write,        // Write request
    input  wire logic [31:0]         avs_writedata,    // Write data
    input  wire logic [3:0]          avs_byteenable,   // Write byte lanes
    output logic [31:0]              avs_readdata,     // Read data
    output logic                     avs_waitrequest,  // Stall master
    // Time references and straps
    input  wire logic [NUM_REF-1:0]  ref_pulse,        // Sat, IRIG, PPS, PTP
    input  wire logic                slot_two_n,       // Low when in slot 2
    // Clocks and clock connectors
    input  wire logic                compensated_oscillator, // Free 10 MHz
    input  wire logic                clock_input_connector,  // Ext 10 MHz
    input  wire logic                backplane_clk10,  // Backplane 10 MHz
    output logic                     clock_output_connector, // Clock out
    output logic                     clk10_repl_out,   // Replacement line
    output logic                     clk10_repl_oe,    // Replacement drive
    // Two-way trigger lines
    input  wire logic [NUM_FP-1:0]   front_panel_io_line_in,  // Panel in
    output logic [NUM_FP-1:0]        front_panel_io_line_out, // Panel out
    output logic [NUM_FP-1:0]        front_panel_io_line_oe,  // Panel drive
    input  wire logic [NUM_STAR-1:0] star_in,          // Star lines in
    output logic [NUM_STAR-1:0]      star_out,         // Star lines out
    output logic [NUM_STAR-1:0]      star_oe,          // Star drive
    input  wire logic [NUM_TRIG-1:0] trig_in,          // Bused lines in
    output logic [NUM_TRIG-1:0]      trig_out,         // Bused lines out
    output logic [NUM_TRIG-1:0]      trig_oe           // Bused drive
);
    localparam int unsigned SYNC_W = NUM_FP + NUM_STAR + NUM_TRIG + 1 +
                                     NUM_REF + 1;

    // Registers
    logic [7:0]        ctrl_q;
    logic [31:0]       time_pre_lo_q;
    logic [31:0]       time_pre_hi_q;
    logic [31:0]       time_snap_q;
    logic [TIME_W-1:0] time_q;
    logic [TIME_W-1:0] evt_time_q;
    logic              armed_q;
    logic              event_q;
    logic [31:0]       gc_high_q;
    logic [31:0]       gc_low_q;
    logic [TIME_W-1:0] gc_start_q;
    logic [TIME_W-1:0] gc_stop_q;
    logic              gc_en_q;
    tr_route_s         route_q [NUM_DEST];
    logic [NUM_DEST-1:0] dest_q;
    logic              slot2_q;
    logic              ack_q;
    logic [31:0]       rdata_q;

    // Synchronisers and edge history
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic              clk10_prev_q;
    logic [NUM_REF-1:0] ref_prev_q;

    logic [NUM_FP-1:0]   fp_s;
    logic [NUM_STAR-1:0] star_s;
    logic [NUM_TRIG-1:0] trig_s;
    logic                clk10_s;
    logic [NUM_REF-1:0]  ref_s;
    logic                slot2_s;
    logic                clk10_rise;
    logic                ref_rise;
    logic [31:0]         src_vec;
    logic                gc_out;
    logic                gc_run;
    logic                wr_en;
    logic                rd_en;
    logic                fire;
    logic [2:0]          ref_sel;
    logic                repl_active;

    // Byte-lane merge of the bus write data into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
                r[8*b +: 8] = avs_writedata[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Panel, star, bused, clk10, reference and slot inputs pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {~slot_two_n, ref_pulse, backplane_clk10, trig_in,
                        star_in, front_panel_io_line_in};
            sync2_q <= sync1_q;
        end
    end

    assign fp_s    = sync2_q[NUM_FP-1:0];
    assign star_s  = sync2_q[NUM_FP +: NUM_STAR];
    assign trig_s  = sync2_q[NUM_FP+NUM_STAR +: NUM_TRIG];
    assign clk10_s = sync2_q[NUM_DEST];
    assign ref_s   = sync2_q[NUM_DEST+1 +: NUM_REF];
    assign slot2_s = sync2_q[SYNC_W-1];

    // Edge history and slot strap caught after reset release
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            clk10_prev_q <= 1'b0;
            ref_prev_q   <= '0;
            slot2_q      <= 1'b0;
        end else begin
            clk10_prev_q <= clk10_s;
            ref_prev_q   <= ref_s;
            slot2_q      <= slot2_s;
        end
    end

    // Sampling a 10 MHz clock at 10 MHz aliases; the edge is only useful
    // when the backplane clock is phase-offset from sys_clk
    assign clk10_rise = clk10_s & ~clk10_prev_q;
    assign ref_sel    = ctrl_q[CTRL_REF_LSB +: 3];

    // Rising edge of the selected reference pulse
    always_comb begin
        case (ref_sel)
            REF_SAT: ref_rise = ref_s[0] & ~ref_prev_q[0]; // (RQ2)
            REF_IRIG: ref_rise = ref_s[1] & ~ref_prev_q[1];
            REF_PPS: ref_rise = ref_s[2] & ~ref_prev_q[2];
            REF_PTP: ref_rise = ref_s[3] & ~ref_prev_q[3];
            default: ref_rise = 1'b0;
        endcase
    end

    // Avalon handshake: one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_en           = avs_write & ack_q;
    assign rd_en           = avs_read & ack_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // Time counter: preset lands on reference edge, or on a high-word
    // write when free running
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            time_q <= '0;
        end else if (ref_sel != REF_FREE && ref_rise) begin // (RQ2)
            time_q <= {time_pre_hi_q, time_pre_lo_q};
        end else if (ref_sel == REF_FREE && wr_en &&
                     avs_address == OFS_TIME_HI) begin
            time_q <= {merge(time_pre_hi_q), time_pre_lo_q};
        end else begin
            time_q <= time_q + TIME_INC; // (RQ1)
        end
    end

    // Future time event: one-cycle pulse, re-arm set wins over fire
    assign fire = armed_q && (time_q >= evt_time_q); // (RQ3)

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            event_q <= fire; // (RQ3)
            if (wr_en && avs_address == OFS_EVT_CTRL && avs_byteenable[0]
                && avs_writedata[0]) begin
                armed_q <= 1'b1;
            end else if (fire) begin
                armed_q <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_q        <= CTRL_RST;
            time_pre_lo_q <= '0;
            time_pre_hi_q <= '0;
            evt_time_q    <= '0;
            gc_high_q     <= '0;
            gc_low_q      <= '0;
            gc_start_q    <= '0;
            gc_stop_q     <= '0;
            gc_en_q       <= 1'b0;
        end else if (wr_en) begin
            case (avs_address)
                OFS_CTRL: ctrl_q <= 8'(merge({24'h0, ctrl_q}));
                OFS_TIME_LO: time_pre_lo_q <= merge(time_pre_lo_q);
                OFS_TIME_HI: time_pre_hi_q <= merge(time_pre_hi_q);
                OFS_EVT_LO: evt_time_q[31:0] <= merge(evt_time_q[31:0]);
                OFS_EVT_HI: evt_time_q[63:32] <= merge(evt_time_q[63:32]);
                OFS_GC_HIGH: gc_high_q <= merge(gc_high_q); // (RQ4)
                OFS_GC_LOW: gc_low_q <= merge(gc_low_q); // (RQ4)
                OFS_GC_STA_L: gc_start_q[31:0] <= merge(gc_start_q[31:0]);
                OFS_GC_STA_H: gc_start_q[63:32] <= merge(gc_start_q[63:32]);
                OFS_GC_STO_L: gc_stop_q[31:0] <= merge(gc_stop_q[31:0]);
                OFS_GC_STO_H: gc_stop_q[63:32] <= merge(gc_stop_q[63:32]);
                OFS_GC_CTRL: begin
                    if (avs_byteenable[0]) begin
                        gc_en_q <= avs_writedata[0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Route table, one word per destination
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_DEST; i++) begin
            if (!reset_n) begin
                route_q[i] <= ROUTE_RST;
            end else if (wr_en && avs_byteenable[0] &&
                         avs_address == OFS_ROUTE0 + 8'(4 * i)) begin
                route_q[i] <= avs_writedata[7:0]; // (RQ17) (RQ12)
            end
        end
    end

    // Register read mux; the low time word snapshots the high word
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_q     <= '0;
            time_snap_q <= '0;
        end else if (avs_read && !ack_q) begin
            rdata_q <= 32'h0;
            case (avs_address)
                OFS_CTRL: rdata_q <= {24'h0, ctrl_q};
                OFS_STATUS: begin
                    rdata_q[STAT_SLOT2]  <= slot2_q;
                    rdata_q[STAT_REPL]   <= repl_active;
                    rdata_q[STAT_ARMED]  <= armed_q;
                    rdata_q[STAT_GC_RUN] <= gc_run;
                end
                OFS_TIME_LO: begin
                    rdata_q     <= time_q[31:0];
                    time_snap_q <= time_q[63:32];
                end
                OFS_TIME_HI: rdata_q <= time_snap_q;
                OFS_EVT_LO: rdata_q <= evt_time_q[31:0];
                OFS_EVT_HI: rdata_q <= evt_time_q[63:32];
                OFS_EVT_CTRL: rdata_q <= {31'h0, armed_q};
                OFS_GC_HIGH: rdata_q <= gc_high_q;
                OFS_GC_LOW: rdata_q <= gc_low_q;
                OFS_GC_STA_L: rdata_q <= gc_start_q[31:0];
                OFS_GC_STA_H: rdata_q <= gc_start_q[63:32];
                OFS_GC_STO_L: rdata_q <= gc_stop_q[31:0];
                OFS_GC_STO_H: rdata_q <= gc_stop_q[63:32];
                OFS_GC_CTRL: rdata_q <= {31'h0, gc_en_q};
                default: begin
                    for (int i = 0; i < NUM_DEST; i++) begin
                        if (avs_address == OFS_ROUTE0 + 8'(4 * i)) begin
                            rdata_q <= {24'h0, route_q[i]};
                        end
                    end
                end
            endcase
        end
    end

    // Time-scheduled clock generator
    tr_clkgen #(
        .LW(32)
    ) u_clkgen (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .enable    (gc_en_q),
        .now       (time_q),
        .start_time(gc_start_q),
        .stop_time (gc_stop_q),
        .high_len  (gc_high_q),
        .low_len   (gc_low_q),
        .clk_out   (gc_out),
        .running   (gc_run)
    );

    // Source vector; the clock input and oscillator have no code here,
    // so they reach trigger lines only via the replacement line and clk10
    assign src_vec = {4'h0, gc_out, event_q, clk10_s, trig_s, star_s,
                      fp_s, 1'b0}; // (RQ13) (RQ15)

    // Destination drivers: select, invert, optional clk10 retiming
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_DEST; i++) begin
            if (!reset_n || !route_q[i].en) begin
                dest_q[i] <= 1'b0; // (RQ17)
            end else if (!route_q[i].sync || route_q[i].src == SRC_EVENT
                         || clk10_rise) begin // (RQ16) (RQ12)
                dest_q[i] <= src_vec[route_q[i].src] ^ route_q[i].inv; // (RQ9)
            end
        end
    end

    // Drive enables follow the route enable; only panel, star and trigger
    // destinations exist, so events never reach clock connectors
    always_comb begin
        for (int i = 0; i < NUM_DEST; i++) begin
            if (i < NUM_FP) begin
                front_panel_io_line_oe[i] = route_q[i].en; // (RQ14)
            end else if (i < NUM_FP + NUM_STAR) begin
                star_oe[i - NUM_FP] = route_q[i].en;
            end else begin
                trig_oe[i - NUM_FP - NUM_STAR] = route_q[i].en;
            end
        end
    end

    assign front_panel_io_line_out = dest_q[NUM_FP-1:0];
    assign star_out = dest_q[NUM_FP +: NUM_STAR];
    assign trig_out = dest_q[NUM_FP+NUM_STAR +: NUM_TRIG];

    // Clock paths are plain muxes of the raw clocks; the oscillator has
    // no trim input, so nothing here can steer it (RQ8)
    assign clock_output_connector = ctrl_q[CTRL_CLOCK_OUTPUT_CONNECTOR] ? backplane_clk10
                                    : compensated_oscillator; // (RQ11)
    assign repl_active = slot2_q & ctrl_q[CTRL_REPL_EN]; // (RQ6) (RQ7)
    assign clk10_repl_oe = repl_active;
    assign clk10_repl_out = repl_active &
        (ctrl_q[CTRL_REPL_SRC] ? clock_input_connector // (RQ10)
                               : compensated_oscillator); // (RQ6)

endmodule
